// ---- rtl/irq_flags_regs.svh ----
// Register offsets, field masks and reset values of the interrupt flag bank
`ifndef IRQ_FLAGS_REGS_SVH
`define IRQ_FLAGS_REGS_SVH

`define ADDR_W        8
`define DATA_W        32
`define FLAG_W        16
`define BANK_COUNT    4

`define FLAGS1_OFS    8'h00
`define FLAGS2_OFS    8'h04
`define FLAGS3_OFS    8'h08
`define FLAGS4_OFS    8'h0C
`define EVT_STAT_OFS  8'h10
`define EVT_MASK_OFS  8'h14

`define FLAGS1_IMPL   16'h000B
`define FLAGS2_IMPL   16'hDFFF
`define FLAGS3_IMPL   16'hA7FF
`define FLAGS4_IMPL   16'h00F7
`define FLAGS_RST     16'h0000
`define EVT_RST       4'h0

`define RESP_OK       2'h0
`define RESP_DEC_ERR  2'h3

`endif

// ---- rtl/irq_flags_pkg.sv ----
// Types of the interrupt flag bank: flag register layouts
`default_nettype none
package irq_flags_pkg;

    typedef struct packed {
        logic [11:0] unused_hi;
        logic        change_notice_flag;
        logic        unused_2;
        logic        twowire_a_master_flag;
        logic        twowire_a_slave_flag;
    } flags1_t;

    typedef struct packed {
        logic timer_six_flag;
        logic dma_ch_four_done_flag;
        logic unused_13;
        logic compare_out_eight_flag;
        logic compare_out_seven_flag;
        logic compare_out_six_flag;
        logic compare_out_five_flag;
        logic capture_six_flag;
        logic capture_five_flag;
        logic capture_four_flag;
        logic capture_three_flag;
        logic dma_ch_three_done_flag;
        logic can_a_event_flag;
        logic can_a_rx_ready_flag;
        logic serial_b_event_flag;
        logic serial_b_error_flag;
    } flags2_t;

    typedef struct packed {
        logic       pwm_fault_a_flag;
        logic       unused_14;
        logic       dma_ch_five_done_flag;
        logic [1:0] unused_12_11;
        logic       encoder_event_flag;
        logic       pwm_error_flag;
        logic       can_b_event_flag;
        logic       can_b_rx_ready_flag;
        logic       ext_pin_four_flag;
        logic       ext_pin_three_flag;
        logic       timer_nine_flag;
        logic       timer_eight_flag;
        logic       twowire_b_master_flag;
        logic       twowire_b_slave_flag;
        logic       timer_seven_flag;
    } flags3_t;

    typedef struct packed {
        logic [7:0] unused_hi;
        logic       can_b_tx_request_flag;
        logic       can_a_tx_request_flag;
        logic       dma_ch_seven_done_flag;
        logic       dma_ch_six_done_flag;
        logic       unused_3;
        logic       uart_b_error_flag;
        logic       uart_a_error_flag;
        logic       pwm_fault_b_flag;
    } flags4_t;

    // One word per flag register, bank 1 in the top 16 bits
    typedef struct packed {
        flags1_t b1;
        flags2_t b2;
        flags3_t b3;
        flags4_t b4;
    } flag_bank_t;

endpackage

`default_nettype wire

// ---- rtl/interrupt_flag_status_bank.sv ----
// Interrupt flag status bank with AXI4-Lite register access
// Contract
// - Flag reads 1 after request, else 0
// - Implemented flags read/write, reset to 0
// - Bank 1: change notice, two-wire A flags
// - Bank 2 high: timer, DMA, compare, capture
// - Bank 2 bit 13 always reads 0
// - Bank 2 low: capture, DMA, CAN A, serial
// - Bank 3 high: fault A, DMA, encoder, CAN
// - Bank 3 bits 14, 12-11 read 0
// - Bank 3 low: CAN B, pins, timers, two-wire
// - Bank 4: CAN requests, DMA six, seven
// - Bank 4 low flags; 15-8, 3 read 0
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_regs.svh"

module interrupt_flag_status_bank
    import irq_flags_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire flag_bank_t           src_events,
    output      flag_bank_t           flags_out,
    output      logic                 irq,
    input  wire logic [`ADDR_W-1:0]   awaddr,
    input  wire logic                 awvalid,
    output      logic                 awready,
    input  wire logic [`DATA_W-1:0]   wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output      logic                 wready,
    output      logic [1:0]           bresp,
    output      logic                 bvalid,
    input  wire logic                 bready,
    input  wire logic [`ADDR_W-1:0]   araddr,
    input  wire logic                 arvalid,
    output      logic                 arready,
    output      logic [`DATA_W-1:0]   rdata,
    output      logic [1:0]           rresp,
    output      logic                 rvalid,
    input  wire logic                 rready
);

    localparam logic [`FLAG_W-1:0] IMPL [`BANK_COUNT] = '{
        `FLAGS1_IMPL, `FLAGS2_IMPL, `FLAGS3_IMPL, `FLAGS4_IMPL};

    logic [`FLAG_W-1:0]  flag_ff   [`BANK_COUNT];
    logic [`FLAG_W-1:0]  nxt_flag  [`BANK_COUNT];
    logic [`FLAG_W-1:0]  ev        [`BANK_COUNT];
    logic [`BANK_COUNT-1:0] stat_ff;
    logic [`BANK_COUNT-1:0] nxt_stat;
    logic [`BANK_COUNT-1:0] mask_ff;
    logic [`BANK_COUNT-1:0] nxt_mask;

    logic                aw_hold_ff;
    logic                nxt_aw_hold;
    logic [`ADDR_W-1:0]  awaddr_ff;
    logic [`ADDR_W-1:0]  nxt_awaddr;
    logic                w_hold_ff;
    logic                nxt_w_hold;
    logic [`DATA_W-1:0]  wdata_ff;
    logic [`DATA_W-1:0]  nxt_wdata;
    logic [3:0]          wstrb_ff;
    logic [3:0]          nxt_wstrb;
    logic                bvalid_ff;
    logic                nxt_bvalid;
    logic [1:0]          bresp_ff;
    logic [1:0]          nxt_bresp;
    logic                rvalid_ff;
    logic                nxt_rvalid;
    logic [`DATA_W-1:0]  rdata_ff;
    logic [`DATA_W-1:0]  nxt_rdata;
    logic [1:0]          rresp_ff;
    logic [1:0]          nxt_rresp;

    logic                aw_got;
    logic                w_got;
    logic                do_wr;
    logic [`ADDR_W-1:0]  wa;
    logic [`DATA_W-1:0]  wd;
    logic [3:0]          ws;
    logic [`FLAG_W-1:0]  wmask;
    logic [5:0]          wr_sel;
    logic [`DATA_W-1:0]  rd_word;
    logic                rd_err;
    logic [63:0]         ev_flat;
    logic [63:0]         flag_flat;
    logic [63:0]         impl_flat;

    assign ev[0] = src_events.b1;
    assign ev[1] = src_events.b2;
    assign ev[2] = src_events.b3;
    assign ev[3] = src_events.b4;
    assign ev_flat   = src_events;
    assign flag_flat = {flag_ff[0], flag_ff[1], flag_ff[2], flag_ff[3]};
    assign impl_flat = {IMPL[0], IMPL[1], IMPL[2], IMPL[3]};
    assign flags_out = flag_flat;

    // Write channel: address and data taken in either order
    assign awready = !aw_hold_ff && !bvalid_ff;
    assign wready  = !w_hold_ff && !bvalid_ff;
    assign aw_got  = aw_hold_ff || (awvalid && awready);
    assign w_got   = w_hold_ff || (wvalid && wready);
    assign do_wr   = aw_got && w_got;
    assign wa      = aw_hold_ff ? awaddr_ff : awaddr;
    assign wd      = w_hold_ff ? wdata_ff : wdata;
    assign ws      = w_hold_ff ? wstrb_ff : wstrb;
    assign wmask   = {{8{ws[1]}}, {8{ws[0]}}};

    always_comb begin
        wr_sel = 6'h00;
        unique case ({wa[`ADDR_W-1:2], 2'h0})
            `FLAGS1_OFS:   wr_sel[0] = 1'b1;
            `FLAGS2_OFS:   wr_sel[1] = 1'b1;
            `FLAGS3_OFS:   wr_sel[2] = 1'b1;
            `FLAGS4_OFS:   wr_sel[3] = 1'b1;
            `EVT_STAT_OFS: wr_sel[4] = 1'b1;
            `EVT_MASK_OFS: wr_sel[5] = 1'b1;
            default:       wr_sel    = 6'h00;
        endcase
    end

    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_w_hold  = w_hold_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (awvalid && awready) begin
            nxt_aw_hold = 1'b1;
            nxt_awaddr  = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w_hold = 1'b1;
            nxt_wdata  = wdata;
            nxt_wstrb  = wstrb;
        end
        if (do_wr) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = (wr_sel == 6'h00) ? `RESP_DEC_ERR : `RESP_OK;
        end else if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // Flags: hardware event wins over a software clear
    always_comb begin
        for (int i = 0; i < `BANK_COUNT; i++) begin
            nxt_flag[i] = flag_ff[i];
            if (do_wr && wr_sel[i]) begin
                nxt_flag[i] = (flag_ff[i] & ~wmask) | (wd[`FLAG_W-1:0] & wmask);
            end
            nxt_flag[i] = (nxt_flag[i] | ev[i]) & IMPL[i];
        end
    end

    // Bank summary: sticky per bank, write one to clear, set wins
    always_comb begin
        nxt_stat = stat_ff;
        nxt_mask = mask_ff;
        if (do_wr && wr_sel[4] && ws[0]) begin
            nxt_stat = stat_ff & ~wd[`BANK_COUNT-1:0];
        end
        if (do_wr && wr_sel[5] && ws[0]) begin
            nxt_mask = wd[`BANK_COUNT-1:0];
        end
        for (int i = 0; i < `BANK_COUNT; i++) begin
            if ((ev[i] & IMPL[i]) != `FLAGS_RST) begin
                nxt_stat[i] = 1'b1;
            end
        end
    end

    assign irq = |(stat_ff & mask_ff);

    // Read channel: one word answered the cycle after the address
    assign arready = !rvalid_ff;

    always_comb begin
        rd_word = '0;
        rd_err  = 1'b0;
        unique case ({araddr[`ADDR_W-1:2], 2'h0})
            `FLAGS1_OFS:   rd_word[`FLAG_W-1:0] = flag_ff[0];
            `FLAGS2_OFS:   rd_word[`FLAG_W-1:0] = flag_ff[1];
            `FLAGS3_OFS:   rd_word[`FLAG_W-1:0] = flag_ff[2];
            `FLAGS4_OFS:   rd_word[`FLAG_W-1:0] = flag_ff[3];
            `EVT_STAT_OFS: rd_word[`BANK_COUNT-1:0] = stat_ff;
            `EVT_MASK_OFS: rd_word[`BANK_COUNT-1:0] = mask_ff;
            default:       rd_err = 1'b1;
        endcase
    end

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (arvalid && arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = rd_word;
            nxt_rresp  = rd_err ? `RESP_DEC_ERR : `RESP_OK;
        end else if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `BANK_COUNT; i++) begin
                flag_ff[i] <= `FLAGS_RST;
            end
            stat_ff    <= `EVT_RST;
            mask_ff    <= `EVT_RST;
            aw_hold_ff <= 1'b0;
            awaddr_ff  <= '0;
            w_hold_ff  <= 1'b0;
            wdata_ff   <= '0;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OK;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= `RESP_OK;
        end else begin
            flag_ff    <= nxt_flag;
            stat_ff    <= nxt_stat;
            mask_ff    <= nxt_mask;
            aw_hold_ff <= nxt_aw_hold;
            awaddr_ff  <= nxt_awaddr;
            w_hold_ff  <= nxt_w_hold;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    assign bvalid = bvalid_ff;
    assign bresp  = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata  = rdata_ff;
    assign rresp  = rresp_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence clear_bank2_s;
        do_wr && wr_sel[1] && (wmask == 16'hFFFF)
            && (wd[`FLAG_W-1:0] == 16'h0000) && (ev[1] == 16'h0000);
    endsequence

    sequence read_bank2_s;
        arvalid && arready && ({araddr[`ADDR_W-1:2], 2'h0} == `FLAGS2_OFS);
    endsequence

    sequence fill_bank3_s;
        do_wr && wr_sel[2] && (wmask == 16'hFFFF) && (wd[`FLAG_W-1:0] == 16'hFFFF);
    endsequence

    event_sets_flag_a: assert property (
        |(ev_flat & impl_flat) |=> ((flag_flat & $past(ev_flat & impl_flat)) == $past(ev_flat & impl_flat)))
        else $error("event did not set its flag");

    no_spurious_flag_a: assert property (
        !do_wr |=> ((flag_flat & ~$past(flag_flat) & ~$past(ev_flat)) == 64'h0))
        else $error("flag rose without event or write");

    write_zero_clears_a: assert property (
        clear_bank2_s |=> (flag_ff[1] == 16'h0000))
        else $error("write of zero left a flag set");

    flag_holds_a: assert property (
        !do_wr |=> ((flag_flat & $past(flag_flat)) == $past(flag_flat)))
        else $error("flag dropped without a write");

    reset_clears_a: assert property (disable iff (1'b0)
        !rst_n |=> (flag_flat == 64'h0) && !irq)
        else $error("flags not zero after reset");

    bank1_notice_a: assert property (
        src_events.b1.change_notice_flag |=> flags_out.b1.change_notice_flag && !flag_ff[0][2])
        else $error("change notice flag missing");

    bank2_timer_a: assert property (
        src_events.b2.timer_six_flag ##0 src_events.b2.capture_six_flag
            |=> flag_ff[1][15] && flag_ff[1][8])
        else $error("bank 2 high flags wrong");

    bank2_gap_a: assert property (
        read_bank2_s |=> rvalid && !rdata[13] && (rdata[`FLAG_W-1:0] == $past(flag_ff[1])))
        else $error("bank 2 read wrong or bit 13 set");

    bank2_low_a: assert property (
        src_events.b2.capture_three_flag |=> flag_ff[1][5] ##0 flags_out.b2.capture_three_flag)
        else $error("capture three flag missing");

    bank3_encoder_a: assert property (
        src_events.b3.encoder_event_flag |=> flag_ff[2][10])
        else $error("encoder flag missing");

    bank3_gaps_a: assert property (
        fill_bank3_s |=> (flag_ff[2][14] == 1'b0) && (flag_ff[2][12:11] == 2'h0) && flag_ff[2][15])
        else $error("bank 3 reserved bits written");

    bank3_timer_a: assert property (
        src_events.b3.timer_seven_flag |=> flag_ff[2][0] [*2])
        else $error("timer seven flag missing");

    bank4_dma_a: assert property (
        src_events.b4.dma_ch_six_done_flag |=> flag_ff[3][4])
        else $error("dma six flag missing");

    bank4_gaps_a: assert property (
        (flag_ff[3][15:8] == 8'h00) && !flag_ff[3][3])
        else $error("bank 4 reserved bits set");

endmodule // interrupt_flag_status_bank

`default_nettype wire

// ---- bench/event_source_model.sv ----
// Peripheral event sources: one-cycle request pulses into the flag bank
`timescale 1ns/1ps
`default_nettype none

module event_source_model
    import irq_flags_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire flag_bank_t pulse_req,
    output var  flag_bank_t src_events
);
    // Requests leave one clock after they are ordered
    always_ff @(posedge core_clk) begin
        src_events <= rst_n ? pulse_req : '0;
    end
endmodule // event_source_model

`default_nettype wire

// ---- bench/interrupt_flag_status_bank_tb.sv ----
// Self-checking testbench of the interrupt flag status bank
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_regs.svh"
`define CHK(g, e) if ((g) !== (e)) begin $display("[ERR] %0t got %0h exp %0h", $time, g, e); err_count++; end n_checks++;

module interrupt_flag_status_bank_tb
    import irq_flags_pkg::*;
;
    localparam logic [63:0] IMPL = {`FLAGS1_IMPL, `FLAGS2_IMPL, `FLAGS3_IMPL, `FLAGS4_IMPL};
    logic               core_clk, rst_n, irq;
    flag_bank_t         src_events, flags_out, pulse_req;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready;
    logic [`ADDR_W-1:0] awaddr, araddr;
    logic [`DATA_W-1:0] wdata, rdata, rd;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, rs;
    int                 err_count = 0;
    int                 n_checks = 0;
    int                 cycles = 0;

    interrupt_flag_status_bank uut (.core_clk, .rst_n, .src_events, .flags_out, .irq,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    event_source_model model (.core_clk, .rst_n, .pulse_req, .src_events);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task results;
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    // Handshakes judged at the falling edge, released after the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_go, w_go, b_go;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_go = 1'b0;
        while (!b_go) begin
            @(negedge core_clk);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            b_go = bvalid === 1'b1;
            rs = bresp;
            @(posedge core_clk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        logic ar_go, r_go;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_go = 1'b0;
        while (!r_go) begin
            @(negedge core_clk);
            ar_go = arvalid && arready;
            r_go = rvalid === 1'b1;
            rd = rdata;
            rs = rresp;
            @(posedge core_clk);
            if (ar_go) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        rdr(a);
        `CHK(rd, {16'h0000, e})
        `CHK(rs, `RESP_OK)
    endtask

    task automatic fire(input logic [63:0] p);
        @(posedge core_clk);
        pulse_req <= p;
        @(posedge core_clk);
        pulse_req <= '0;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic clear_all;
        for (int i = 0; i < 4; i++) begin
            wr(8'(i * 4), 32'h00000000, 4'hF);
            `CHK(rs, `RESP_OK)
            rchk(8'(i * 4), 16'h0000);
        end
    endtask

    task automatic t_reset_values;
        for (int i = 0; i < 6; i++) rchk(8'(i * 4), 16'h0000);
    endtask

    task automatic t_walk;
        logic [63:0] exp;
        exp = '0;
        for (int i = 0; i < 64; i++) begin
            fire(64'h1 << i);
            exp[i] = IMPL[i];
            `CHK(flags_out, exp)
        end
        for (int i = 0; i < 4; i++) rchk(8'(i * 4), IMPL[63 - 16 * i -: 16]);
    endtask

    task automatic t_named;
        flag_bank_t ev;
        ev = '0;
        ev.b1.change_notice_flag = 1'b1;
        ev.b2.timer_six_flag = 1'b1;
        ev.b3.pwm_fault_a_flag = 1'b1;
        ev.b3.timer_seven_flag = 1'b1;
        ev.b4.pwm_fault_b_flag = 1'b1;
        fire(ev);
        rchk(8'h00, 16'h0008);
        rchk(8'h04, 16'h8000);
        rchk(8'h08, 16'h8001);
        rchk(8'h0C, 16'h0001);
    endtask

    task automatic t_sw_write;
        for (int i = 0; i < 4; i++) begin
            wr(8'(i * 4), 32'hFFFFFFFF, 4'hF);
            rchk(8'(i * 4), IMPL[63 - 16 * i -: 16]);
        end
        // Upper byte lane only: low flags keep their ones
        wr(8'h04, 32'h00000000, 4'h2);
        rchk(8'h04, 16'h00FF);
    endtask

    task automatic t_irq;
        wr(8'h10, 32'h0000000F, 4'h1);
        rchk(8'h10, 16'h0000);
        fire(64'h0000000000010000);
        rchk(8'h10, 16'h0004);
        `CHK(irq, 1'b0)
        wr(8'h14, 32'h00000004, 4'h1);
        `CHK(irq, 1'b1)
        wr(8'h10, 32'h00000004, 4'h1);
        `CHK(irq, 1'b0)
        rchk(8'h08, 16'h0001);
    endtask

    task automatic t_unmapped;
        wr(8'h20, 32'h0000FFFF, 4'hF);
        `CHK(rs, `RESP_DEC_ERR)
        rdr(8'h20);
        `CHK(rd, 32'h00000000)
        `CHK(rs, `RESP_DEC_ERR)
        // Unmapped write must leave the flags alone
        rchk(8'h00, 16'h0000);
    endtask

    task automatic t_reset_mid;
        fire('1);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        `CHK(flags_out, 64'h0000000000000000)
        `CHK(irq, 1'b0)
    endtask

    initial begin
        rst_n = 1'b0;
        pulse_req = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_walk();
        clear_all();
        t_named();
        t_sw_write();
        clear_all();
        t_irq();
        t_unmapped();
        t_reset_mid();
        results();
    end
endmodule // interrupt_flag_status_bank_tb

`default_nettype wire
